// ### tmtx_bit_engine.sv
`timescale 1ns/1ps
module tmtx_bit_engine (
  // system
  input wire logic     clk,
  input wire logic     rst,
  // byte controller side
  tmtx_link_if.engine  lnk
);

  typedef enum {ENG_IDLE, ENG_Q0, ENG_Q1, ENG_Q2, ENG_Q3} tmtx_eng_t;

  tmtx_eng_t           state_reg;
  tmtx_pkg::tmtx_cmd_t cmd_reg;
  logic                bit_reg;
  logic [8:0]          tick_reg;
  logic                sda_prev_reg;
  logic                tick_done;
  logic                q1_end;
  logic                lose_now;

  // the high quarter only runs while scl is really high, so a stretching slave holds us
  assign tick_done = (tick_reg == tmtx_pkg::QUARTER_LAST) && (state_reg != ENG_Q1 || lnk.scl_s);
  assign q1_end    = (state_reg == ENG_Q1) && tick_done;
  assign lose_now  = q1_end && cmd_reg == tmtx_pkg::TMTX_CMD_BIT && bit_reg && !lnk.sda_s;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= ENG_IDLE;
      cmd_reg   <= tmtx_pkg::TMTX_CMD_BIT;
      bit_reg   <= 1'b1;
      tick_reg  <= 9'h000;
    end
    else
    begin
      if (state_reg == ENG_IDLE || tick_done)
        tick_reg <= 9'h000;
      else if (state_reg != ENG_Q1 || lnk.scl_s)
        tick_reg <= tick_reg + 9'h001;
      case (state_reg)
        ENG_IDLE:
        begin
          if (lnk.req)
          begin
            state_reg <= ENG_Q0;
            cmd_reg   <= lnk.cmd;
            bit_reg   <= lnk.tx_bit;
          end
        end
        ENG_Q0:  if (tick_done) state_reg <= ENG_Q1;
        ENG_Q1:  if (tick_done) state_reg <= lose_now ? ENG_IDLE : ENG_Q2;
        ENG_Q2:  if (tick_done) state_reg <= ENG_Q3;
        ENG_Q3:  if (tick_done) state_reg <= ENG_IDLE;
        default: state_reg <= ENG_IDLE;
      endcase
    end
  end

  // line drivers; scl stays low after a bit so the bus waits for software
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      lnk.scl_low <= 1'b0;
      lnk.sda_low <= 1'b0;
    end
    else if (state_reg == ENG_IDLE && lnk.req)
    begin
      case (lnk.cmd)
        tmtx_pkg::TMTX_CMD_START: lnk.sda_low <= 1'b0;
        tmtx_pkg::TMTX_CMD_STOP:  lnk.sda_low <= 1'b1;
        default:                  lnk.sda_low <= !lnk.tx_bit;
      endcase
    end
    else if (state_reg == ENG_Q0 && tick_done)
      lnk.scl_low <= 1'b0;
    else if (q1_end)
    begin
      if (lose_now)
      begin
        lnk.scl_low <= 1'b0;
        lnk.sda_low <= 1'b0;
      end
      else if (cmd_reg == tmtx_pkg::TMTX_CMD_START)
        lnk.sda_low <= 1'b1;
      else if (cmd_reg == tmtx_pkg::TMTX_CMD_STOP)
        lnk.sda_low <= 1'b0;
    end
    else if (state_reg == ENG_Q2 && tick_done && cmd_reg != tmtx_pkg::TMTX_CMD_STOP)
      lnk.scl_low <= 1'b1;
  end

  // completion, sampled bit and arbitration result
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      lnk.done   <= 1'b0;
      lnk.lost   <= 1'b0;
      lnk.rx_bit <= 1'b1;
    end
    else
    begin
      lnk.done <= lose_now || (state_reg == ENG_Q3 && tick_done);
      if (q1_end)
      begin
        lnk.rx_bit <= lnk.sda_s;
        lnk.lost   <= lose_now;
      end
    end
  end

  // start and stop seen on the wire mark the bus busy or free
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sda_prev_reg <= 1'b1;
      lnk.bus_busy <= 1'b0;
    end
    else
    begin
      sda_prev_reg <= lnk.sda_s;
      if (lnk.scl_s && sda_prev_reg && !lnk.sda_s)
        lnk.bus_busy <= 1'b1;
      else if (lnk.scl_s && !sda_prev_reg && lnk.sda_s)
        lnk.bus_busy <= 1'b0;
    end
  end

endmodule

// ### tmtx_bus_partner.sv
`timescale 1ns/1ps
module tmtx_bus_partner (
  // wire levels
  input wire logic scl,
  input wire logic sda,
  // behaviour knobs
  input wire logic ack_en,
  input wire logic jam,
  input wire logic stretch,
  // open-drain pulls, high pulls the line low
  output logic     scl_low,
  output logic     sda_low
);
  int   bit_cnt = -1;
  logic ack_low = 1'b0;
  logic jam_low = 1'b0;

  assign sda_low = ack_low | jam_low;
  initial scl_low = 1'b0;

  ////////////////////////////////////////////////////////////
  // start or repeated start restarts the bit count
  always @(negedge sda)
    if (scl === 1'b1)
      bit_cnt = -1;

  // ack slot opens on the eighth falling edge, closes on the ninth
  always @(negedge scl)
  begin
    bit_cnt++;
    if (bit_cnt == 8)
      ack_low = ack_en;
    else if (bit_cnt == 9)
    begin
      ack_low = 1'b0;
      bit_cnt = 0;
    end
  end

  // rival master: starts pulling only while scl is low, lets go at once (a stop)
  always @(scl, jam)
    if (scl === 1'b0 || !jam)
      jam_low = jam;

  // slow device: holds scl beyond the master's own low phase
  always @(negedge scl)
    if (stretch)
    begin
      scl_low = 1'b1;
      #7000;
      scl_low = 1'b0;
    end
endmodule

// ### tmtx_link_if.sv
`timescale 1ns/1ps
interface tmtx_link_if;
  logic                req;
  tmtx_pkg::tmtx_cmd_t cmd;
  logic                tx_bit;
  logic                done;
  logic                rx_bit;
  logic                lost;
  logic                bus_busy;
  logic                scl_s;
  logic                sda_s;
  logic                scl_low;
  logic                sda_low;

  modport engine (input req, cmd, tx_bit, scl_s, sda_s,
                  output done, rx_bit, lost, bus_busy, scl_low, sda_low);
  modport ctrl   (output req, cmd, tx_bit, scl_s, sda_s,
                  input done, rx_bit, lost, bus_busy, scl_low, sda_low);
endinterface

// ### tmtx_master_tx.sv
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
module tmtx_master_tx (
  // system
  input  wire logic       clk,
  input  wire logic       rst,
  // register port
  input  wire logic [1:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // processor side
  input  wire logic       cpu_global_irq_enable,
  output logic            irq,
  output logic            master_rx_handoff,
  // open-drain bus lines
  input  wire logic       scl_in,
  output logic            scl_out,
  output logic            scl_oe_n,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n
);

  typedef enum {TX_IDLE, TX_WAIT_FREE, TX_START, TX_STOP, TX_SHIFT, TX_ACK, TX_HOLD} tmtx_state_t;

  tmtx_link_if lnk ();

  tmtx_state_t state_reg;
  logic        op_complete_flag;
  logic        bus_irq_enable;
  logic        ack_on_receive_enable;
  logic        begin_condition_request;
  logic        halt_request_bit;
  logic        engine_enable;
  logic [7:0]  bus_data_reg;
  logic [7:0]  status_code_reg;
  logic [1:0]  presc_reg;
  logic [7:0]  shift_reg;
  logic [2:0]  bit_cnt_reg;
  logic        owner_reg;
  logic        addr_phase_reg;
  logic        chain_start_reg;
  logic        req_reg;
  logic        set_flag;
  logic [7:0]  set_code;
  logic        stop_done;
  logic        release_wr;
  logic        in_tx_state;
  logic        scl_meta_reg;
  logic        scl_sync_reg;
  logic        sda_meta_reg;
  logic        sda_sync_reg;

  tmtx_bit_engine u_engine (
    .clk (clk),
    .rst (rst),
    .lnk (lnk)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and drivers

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      scl_meta_reg <= 1'b1;
      scl_sync_reg <= 1'b1;
      sda_meta_reg <= 1'b1;
      sda_sync_reg <= 1'b1;
    end
    else
    begin
      scl_meta_reg <= scl_in;
      scl_sync_reg <= scl_meta_reg;
      sda_meta_reg <= sda_in;
      sda_sync_reg <= sda_meta_reg;
    end
  end

  assign lnk.scl_s = scl_sync_reg;
  assign lnk.sda_s = sda_sync_reg;
  // open drain: drive only low, float otherwise
  assign scl_out   = 1'b0;
  assign sda_out   = 1'b0;
  assign scl_oe_n  = !lnk.scl_low;
  assign sda_oe_n  = !lnk.sda_low;

  ////////////////////////////////////////////////////////////////////////////
  // register port

  assign release_wr  = reg_wr && reg_addr == tmtx_pkg::ADDR_CONTROL && reg_wdata[tmtx_pkg::CTL_FLAG_BIT];
  assign in_tx_state = status_code_reg == tmtx_pkg::ST_ADDR_ACK || status_code_reg == tmtx_pkg::ST_ADDR_NACK ||
                       status_code_reg == tmtx_pkg::ST_DATA_ACK || status_code_reg == tmtx_pkg::ST_DATA_NACK;
  assign stop_done   = state_reg == TX_STOP && lnk.done;

  // software write of the stop bit wins over the hardware clear in the same cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      bus_irq_enable          <= tmtx_pkg::CONTROL_RST[tmtx_pkg::CTL_IRQ_EN_BIT];
      ack_on_receive_enable   <= tmtx_pkg::CONTROL_RST[tmtx_pkg::CTL_ACK_EN_BIT];
      begin_condition_request <= tmtx_pkg::CONTROL_RST[tmtx_pkg::CTL_BEGIN_BIT];
      halt_request_bit        <= tmtx_pkg::CONTROL_RST[tmtx_pkg::CTL_HALT_BIT];
      engine_enable           <= tmtx_pkg::CONTROL_RST[tmtx_pkg::CTL_ENABLE_BIT];
    end
    else if (reg_wr && reg_addr == tmtx_pkg::ADDR_CONTROL)
    begin
      bus_irq_enable          <= reg_wdata[tmtx_pkg::CTL_IRQ_EN_BIT];
      ack_on_receive_enable   <= reg_wdata[tmtx_pkg::CTL_ACK_EN_BIT];
      begin_condition_request <= reg_wdata[tmtx_pkg::CTL_BEGIN_BIT];
      halt_request_bit        <= reg_wdata[tmtx_pkg::CTL_HALT_BIT];
      engine_enable           <= reg_wdata[tmtx_pkg::CTL_ENABLE_BIT];
    end
    else if (stop_done)
      halt_request_bit <= 1'b0;
  end

  // flag set by an event wins over a release write in the same cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      op_complete_flag <= tmtx_pkg::FLAG_RST;
    else if (set_flag)
      op_complete_flag <= 1'b1;
    else if (release_wr)
      op_complete_flag <= 1'b0;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      bus_data_reg <= tmtx_pkg::DATA_RST;
      presc_reg    <= tmtx_pkg::PRESC_RST;
    end
    else if (reg_wr && reg_addr == tmtx_pkg::ADDR_DATA)
      bus_data_reg <= reg_wdata;
    else if (reg_wr && reg_addr == tmtx_pkg::ADDR_STATUS)
      presc_reg <= reg_wdata[tmtx_pkg::STS_PRESC_MSB:tmtx_pkg::STS_PRESC_LSB];
  end

  // read data stand only in the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (!reg_rd)
      reg_rdata <= 8'h00;
    else
    begin
      case (reg_addr)
        tmtx_pkg::ADDR_CONTROL:
          reg_rdata <= {op_complete_flag, ack_on_receive_enable, begin_condition_request, halt_request_bit,
                        1'b0, engine_enable, 1'b0, bus_irq_enable};
        tmtx_pkg::ADDR_STATUS: reg_rdata <= (status_code_reg & tmtx_pkg::ST_CODE_MASK) | {6'h00, presc_reg};
        tmtx_pkg::ADDR_DATA:   reg_rdata <= bus_data_reg;
        default:               reg_rdata <= 8'h00;
      endcase
    end
  end

  assign irq = op_complete_flag && bus_irq_enable && cpu_global_irq_enable;

  ////////////////////////////////////////////////////////////////////////////
  // byte sequencer

  assign lnk.req    = req_reg;
  assign lnk.cmd    = state_reg == TX_START ? tmtx_pkg::TMTX_CMD_START : state_reg == TX_ACK ? tmtx_pkg::TMTX_CMD_ACK :
                      state_reg == TX_STOP  ? tmtx_pkg::TMTX_CMD_STOP  : tmtx_pkg::TMTX_CMD_BIT;
  // during the acknowledge slot sda is released for the slave
  assign lnk.tx_bit = state_reg == TX_ACK ? 1'b1 : shift_reg[7];

  always_comb
  begin
    set_flag = 1'b0;
    set_code = status_code_reg;
    if (lnk.done)
    begin
      case (state_reg)
        TX_START:
        begin
          set_flag = 1'b1;
          set_code = owner_reg ? tmtx_pkg::ST_RESTART : tmtx_pkg::ST_START;
        end
        TX_SHIFT:
        begin
          set_flag = lnk.lost;
          set_code = tmtx_pkg::ST_ARB_LOST;
        end
        TX_ACK:
        begin
          set_flag = 1'b1;
          if (addr_phase_reg && bus_data_reg[0])
            set_code = tmtx_pkg::ST_IDLE;
          else if (addr_phase_reg)
            set_code = lnk.rx_bit ? tmtx_pkg::ST_ADDR_NACK : tmtx_pkg::ST_ADDR_ACK;
          else
            set_code = lnk.rx_bit ? tmtx_pkg::ST_DATA_NACK : tmtx_pkg::ST_DATA_ACK;
        end
        default:
        begin
          set_flag = 1'b0;
          set_code = status_code_reg;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      status_code_reg <= tmtx_pkg::ST_IDLE;
    else if (set_flag)
      status_code_reg <= set_code;
    else if (stop_done || (release_wr && state_reg == TX_HOLD && !owner_reg))
      status_code_reg <= tmtx_pkg::ST_IDLE;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg         <= TX_IDLE;
      req_reg           <= 1'b0;
      shift_reg         <= 8'h00;
      bit_cnt_reg       <= 3'h0;
      owner_reg         <= 1'b0;
      addr_phase_reg    <= 1'b0;
      chain_start_reg   <= 1'b0;
      master_rx_handoff <= 1'b0;
    end
    else
    begin
      req_reg <= 1'b0;
      case (state_reg)
        TX_IDLE, TX_HOLD:
        begin
          if (release_wr)
          begin
            master_rx_handoff <= 1'b0;
            if (reg_wdata[tmtx_pkg::CTL_HALT_BIT] && owner_reg)
            begin
              state_reg       <= TX_STOP;
              req_reg         <= 1'b1;
              chain_start_reg <= reg_wdata[tmtx_pkg::CTL_BEGIN_BIT];
            end
            else if (reg_wdata[tmtx_pkg::CTL_BEGIN_BIT] && (owner_reg || reg_wdata[tmtx_pkg::CTL_ENABLE_BIT]))
            begin
              if (!owner_reg && lnk.bus_busy)
                state_reg <= TX_WAIT_FREE;
              else
              begin
                state_reg <= TX_START;
                req_reg   <= 1'b1;
              end
            end
            else if (owner_reg && (in_tx_state || status_code_reg == tmtx_pkg::ST_START ||
                                   status_code_reg == tmtx_pkg::ST_RESTART))
            begin
              state_reg      <= TX_SHIFT;
              req_reg        <= 1'b1;
              shift_reg      <= bus_data_reg;
              bit_cnt_reg    <= 3'h0;
              addr_phase_reg <= !in_tx_state;
            end
            else
              state_reg <= TX_IDLE;
          end
        end
        TX_WAIT_FREE:
        begin
          if (!lnk.bus_busy)
          begin
            state_reg <= TX_START;
            req_reg   <= 1'b1;
          end
        end
        TX_START:
        begin
          if (lnk.done)
          begin
            state_reg <= TX_HOLD;
            owner_reg <= 1'b1;
          end
        end
        TX_STOP:
        begin
          if (lnk.done)
          begin
            owner_reg       <= 1'b0;
            chain_start_reg <= 1'b0;
            state_reg       <= chain_start_reg ? TX_WAIT_FREE : TX_IDLE;
          end
        end
        TX_SHIFT:
        begin
          if (lnk.done && lnk.lost)
          begin
            state_reg <= TX_HOLD;
            owner_reg <= 1'b0;
          end
          else if (lnk.done)
          begin
            shift_reg   <= {shift_reg[6:0], 1'b0};
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            req_reg     <= 1'b1;
            if (bit_cnt_reg == tmtx_pkg::BYTE_LAST_BIT)
              state_reg <= TX_ACK;
          end
        end
        TX_ACK:
        begin
          if (lnk.done)
          begin
            state_reg <= TX_HOLD;
            if (addr_phase_reg && bus_data_reg[0] && !lnk.rx_bit)
              master_rx_handoff <= 1'b1;
          end
        end
        default: state_reg <= TX_IDLE;
      endcase
    end
  end

endmodule

// ### tmtx_master_tx_sva.sv
`timescale 1ns/1ps
module tmtx_master_tx_sva (
  // system
  input wire logic       clk,
  input wire logic       rst,
  // register port
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // processor side
  input wire logic       cpu_global_irq_enable,
  input wire logic       irq,
  input wire logic       master_rx_handoff,
  // bus lines
  input wire logic       scl_in,
  input wire logic       scl_out,
  input wire logic       scl_oe_n,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its read cycle");
  a_unmapped_zero: assert property ($past(reg_rd) && $past(reg_addr) == 2'h3 |-> reg_rdata == 8'h00)
    else $error("unmapped index read not zero");
  a_status_legal: assert property ($past(reg_rd) && $past(reg_addr) == tmtx_pkg::ADDR_STATUS |->
    (reg_rdata & tmtx_pkg::ST_CODE_MASK) inside {8'h08, 8'h10, 8'h18, 8'h20, 8'h28, 8'h30, 8'h38, 8'hf8})
    else $error("status code outside transmitter set");
  a_irq_gated: assert property (!cpu_global_irq_enable |-> !irq)
    else $error("irq raised without global enable");
  // the engine needs a full quarter before any event can complete
  a_release_quiet: assert property ($past(reg_wr) && $past(reg_addr) == tmtx_pkg::ADDR_CONTROL
    && $past(reg_wdata[7]) |-> !irq [*8])
    else $error("flag not cleared by release");
  a_flag_holds_lines: assert property (irq && $past(irq) |-> $stable(scl_oe_n) && $stable(sda_oe_n))
    else $error("bus lines moved while flag set");
  a_start_shape: assert property ($fell(sda_oe_n) && scl_in |-> ##[300:330] $fell(scl_oe_n))
    else $error("start not followed by clock low after a quarter");
  a_stop_frees: assert property ($rose(sda_oe_n) && scl_in |-> scl_oe_n [*8])
    else $error("clock pulled right after stop");
endmodule

// ### tmtx_master_tx_test.sv
`timescale 1ns/1ps
bind tmtx_master_tx tmtx_master_tx_sva tmtx_master_tx_sva_inst (.clk(clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .cpu_global_irq_enable(cpu_global_irq_enable), .irq(irq), .master_rx_handoff(master_rx_handoff),
  .scl_in(scl_in), .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n));

module tmtx_master_tx_test;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [1:0]  reg_addr = 2'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_rdata;
  logic        cpu_global_irq_enable = 1'b1;
  logic        irq;
  logic        master_rx_handoff;
  logic        scl_in;
  logic        scl_out;
  logic        scl_oe_n;
  logic        sda_in;
  logic        sda_out;
  logic        sda_oe_n;
  logic        scl_low;
  logic        sda_low;
  logic        ack_en = 1'b1;
  logic        jam = 1'b0;
  logic        stretch = 1'b0;
  logic [31:0] rnd = 32'h897f;
  logic [7:0]  rd_val;
  int          miscompares = 0;
  int          check_count = 0;
  int          cycles = 0;

  always #4 clk = ~clk;

  // pull-ups: a released line reads high
  assign scl_in = scl_oe_n & ~scl_low;
  assign sda_in = sda_oe_n & ~sda_low;

  tmtx_master_tx tmtx_master_tx_inst (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_global_irq_enable(cpu_global_irq_enable),
    .irq(irq), .master_rx_handoff(master_rx_handoff), .scl_in(scl_in), .scl_out(scl_out),
    .scl_oe_n(scl_oe_n), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n));

  tmtx_bus_partner tmtx_bus_partner_inst (.scl(scl_in), .sda(sda_in), .ack_en(ack_en), .jam(jam),
    .stretch(stretch), .scl_low(scl_low), .sda_low(sda_low));

  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [7:0] ctl(input logic b, input logic h);
    logic [7:0] c;
    c = 8'h85;
    c[tmtx_pkg::CTL_BEGIN_BIT]  = b;
    c[tmtx_pkg::CTL_HALT_BIT]   = h;
    c[tmtx_pkg::CTL_ACK_EN_BIT] = rnd[3];
    return c;
  endfunction

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic reg_read(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic wait_flag();
    do
      reg_read(tmtx_pkg::ADDR_CONTROL, rd_val);
    while (rd_val[tmtx_pkg::CTL_FLAG_BIT] !== 1'b1);
  endtask

  task automatic read_status(input logic [7:0] exp);
    reg_read(tmtx_pkg::ADDR_STATUS, rd_val);
    check("status", rd_val & tmtx_pkg::ST_CODE_MASK, exp);
  endtask

  task automatic step(input logic b, input logic h, input logic [7:0] d, input logic [7:0] exp);
    rnd = lfsr(rnd);
    reg_write(tmtx_pkg::ADDR_DATA, d);
    reg_write(tmtx_pkg::ADDR_CONTROL, ctl(b, h));
    wait_flag();
    read_status(exp);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // the planned traffic needs about 70000 cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 95000)
    begin
      miscompares++;
      $display("[ERR] run expected finished seen hanging");
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    reg_read(tmtx_pkg::ADDR_CONTROL, rd_val);
    check("control reset", rd_val, tmtx_pkg::CONTROL_RST);
    read_status(tmtx_pkg::ST_IDLE);
    reg_read(tmtx_pkg::ADDR_DATA, rd_val);
    check("data reset", rd_val, tmtx_pkg::DATA_RST);
    rnd = lfsr(rnd);
    reg_write(tmtx_pkg::ADDR_STATUS, rnd[7:0]);
    reg_write(2'h3, rnd[15:8]);
    reg_read(tmtx_pkg::ADDR_STATUS, rd_val);
    check("status write", rd_val, tmtx_pkg::ST_IDLE | {6'h00, rnd[1:0]});
    reg_read(2'h3, rd_val);
    check("unmapped", rd_val, 8'h00);
    reg_write(tmtx_pkg::ADDR_DATA, rnd[23:16]);
    reg_read(tmtx_pkg::ADDR_DATA, rd_val);
    check("data", rd_val, rnd[23:16]);
    $display("test registers done");

    step(1'b1, 1'b0, 8'h00, tmtx_pkg::ST_START);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk);
      cpu_global_irq_enable <= i[1];
      reg_write(tmtx_pkg::ADDR_CONTROL, {7'h02, i[0]});
      #1;
      check("irq", {7'h00, irq}, {7'h00, i[1] & i[0]});
    end
    $display("test irq done");

    step(1'b0, 1'b0, {rnd[14:8], 1'b0}, tmtx_pkg::ST_ADDR_ACK);
    stretch <= 1'b1;
    step(1'b0, 1'b0, rnd[7:0], tmtx_pkg::ST_DATA_ACK);
    stretch <= 1'b0;
    ack_en <= 1'b0;
    step(1'b0, 1'b0, rnd[15:8], tmtx_pkg::ST_DATA_NACK);
    step(1'b1, 1'b0, 8'h00, tmtx_pkg::ST_RESTART);
    step(1'b0, 1'b0, {rnd[6:0], 1'b0}, tmtx_pkg::ST_ADDR_NACK);
    ack_en <= 1'b1;
    step(1'b1, 1'b0, 8'h00, tmtx_pkg::ST_RESTART);
    step(1'b0, 1'b0, {rnd[6:0], 1'b1}, tmtx_pkg::ST_IDLE);
    check("handoff", {7'h00, master_rx_handoff}, 8'h01);
    step(1'b1, 1'b1, 8'h00, tmtx_pkg::ST_START);
    reg_read(tmtx_pkg::ADDR_CONTROL, rd_val);
    check("halt bit", {7'h00, rd_val[tmtx_pkg::CTL_HALT_BIT]}, 8'h00);
    check("handoff", {7'h00, master_rx_handoff}, 8'h00);
    $display("test transfer done");

    jam <= 1'b1;
    step(1'b0, 1'b0, {1'b1, rnd[6:0]}, tmtx_pkg::ST_ARB_LOST);
    check("lines released", {6'h00, scl_oe_n, sda_oe_n}, 8'h03);
    check("drive level", {6'h00, scl_out, sda_out}, 8'h00);
    reg_write(tmtx_pkg::ADDR_CONTROL, ctl(1'b1, 1'b0));
    // observation window only: the bus stays busy until the rival lets go
    repeat (2000) @(posedge clk);
    reg_read(tmtx_pkg::ADDR_CONTROL, rd_val);
    check("start while busy", {7'h00, rd_val[tmtx_pkg::CTL_FLAG_BIT]}, 8'h00);
    jam <= 1'b0;
    wait_flag();
    read_status(tmtx_pkg::ST_START);
    $display("test arbitration done");

    reg_write(tmtx_pkg::ADDR_CONTROL, ctl(1'b0, 1'b1));
    do
      reg_read(tmtx_pkg::ADDR_CONTROL, rd_val);
    while (rd_val[tmtx_pkg::CTL_HALT_BIT] !== 1'b0);
    check("flag after stop", {7'h00, rd_val[tmtx_pkg::CTL_FLAG_BIT]}, 8'h00);
    read_status(tmtx_pkg::ST_IDLE);
    $display("test stop done");
    print_verdict();
  end
endmodule

// ### tmtx_pkg.sv
package tmtx_pkg;

  // clock and bus bit timing
  localparam int CLK_PERIOD_PS = 8000;
  localparam int QUARTER_NS    = 2500;
  localparam int QUARTER_CYC   = (QUARTER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [8:0] QUARTER_LAST = 9'(QUARTER_CYC - 1);
  localparam logic [2:0] BYTE_LAST_BIT = 3'h7;

  // register map, one index per register
  localparam logic [1:0] ADDR_CONTROL = 2'h0;
  localparam logic [1:0] ADDR_STATUS  = 2'h1;
  localparam logic [1:0] ADDR_DATA    = 2'h2;

  // bus_control_reg fields
  localparam int CTL_FLAG_BIT   = 7;
  localparam int CTL_ACK_EN_BIT = 6;
  localparam int CTL_BEGIN_BIT  = 5;
  localparam int CTL_HALT_BIT   = 4;
  localparam int CTL_ENABLE_BIT = 2;
  localparam int CTL_IRQ_EN_BIT = 0;

  // bus_status_reg fields
  localparam int STS_PRESC_LSB = 0;
  localparam int STS_PRESC_MSB = 1;

  // values after reset
  localparam logic       FLAG_RST   = 1'b0;
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] DATA_RST    = 8'hff;
  localparam logic [1:0] PRESC_RST   = 2'h0;

  // status codes, prescaler bits masked
  localparam logic [7:0] ST_START     = 8'h08;
  localparam logic [7:0] ST_RESTART   = 8'h10;
  localparam logic [7:0] ST_ADDR_ACK  = 8'h18;
  localparam logic [7:0] ST_ADDR_NACK = 8'h20;
  localparam logic [7:0] ST_DATA_ACK  = 8'h28;
  localparam logic [7:0] ST_DATA_NACK = 8'h30;
  localparam logic [7:0] ST_ARB_LOST  = 8'h38;
  localparam logic [7:0] ST_IDLE      = 8'hf8;
  localparam logic [7:0] ST_CODE_MASK = 8'hf8;

  typedef enum logic [1:0] {
    TMTX_CMD_START,
    TMTX_CMD_STOP,
    TMTX_CMD_BIT,
    // released acknowledge slot: the slave owns sda, so no arbitration there
    TMTX_CMD_ACK
  } tmtx_cmd_t;

endpackage
